// ===== design/cat_counter_array.sv
// Shared 16-bit counter, timebase, overflow flags, channel flags and interrupt request.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - One 16-bit up-counter read as low byte and high byte.
// - Reading low byte latches high byte; next high read returns latched value.
// - Counter reads never disturb counting.
// - Three-bit select picks div12, div4, timer0 overflow, pin, sysclk, oscillator div8.
// - Count pin falling edges; source must stay below sysclk divided by four.
// - Oscillator div8 timebase synchronised into system clock before counting.
// - Wrap from FFFF to 0000 sets count overflow flag.
// - Count overflow enable lets that flag raise the request.
// - Hardware never clears count overflow flag on vectoring; software clears it.
// - Idle suspend zero keeps counter running during processor idle.
// - Intermediate flag set on overflow from bit 8, 9, 10 or 11.
// - Six channels each have their own event flag set by mode.
// - Flags set on trigger regardless of interrupt enables.
// - Request is OR of each flag ANDed with its own enable.
// - Processor sees request only with global and block enable set.
// - Each channel drives its own line, routed by the crossbar.
// - Channels support capture, timer, fast output, 8-11 PWM, 16 PWM.
// - Channel 5 watchdog on after reset restricts some register writes.
// - Two-bit length selects intermediate bit 8 to 11, shared by PWM.
module cat_counter_array (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rstn,
  // Register port.
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // System inputs.
  input wire logic i_cpu_idle,
  input wire logic i_timer0_ovf,
  input wire logic i_global_irq_enable,
  input wire logic i_array_irq_enable,
  input wire logic i_external_count_pin,
  input wire logic i_ext_osc,
  input wire logic [cat_pkg::CAT_NCH-1:0] i_channel_io_line,
  // Outputs.
  output logic [cat_pkg::CAT_NCH-1:0] o_channel_io_line,
  output logic o_irq
);
  import cat_pkg::*;

  logic [15:0] count_q;
  logic [7:0] snap_q;
  logic [7:0] mode_q;
  logic [7:0] ctrl_q;
  logic [CAT_NCH-1:0] ch_flag_q;
  logic [CAT_NCH-1:0] ch_en_q;
  logic [7:0] ch_mode_q [CAT_NCH];
  logic [15:0] ch_cmp_q [CAT_NCH];
  logic [15:0] ch_cap_q [CAT_NCH];
  logic [CAT_NCH-1:0] ch_out_q;
  logic [3:0] div12_q;
  logic [1:0] div4_q;
  logic [2:0] osc_div_q;
  logic [2:0] osc_sync_q;
  logic [2:0] pin_sync_q;
  logic [CAT_NCH-1:0] cex_s1_q, cex_s2_q, cex_s3_q;
  logic [7:0] rd_mux;
  logic tick;
  logic wrap;
  logic mid_ovf;
  logic run;
  logic wdt_on;
  logic [CAT_NCH-1:0] ch_set;
  logic wr_low;
  logic wr_high;
  logic wr_mode;
  logic wr_ctrl;
  logic wr_flags;
  logic wr_en;
  logic wr_chan;
  logic rd_low;
  logic src_cf;
  logic src_intermediate_overflow_flag;
  logic src_ch;
  logic irq_d;

  // One decoder for every fixed-offset register strobe keeps the map in a single place; channel writes decode a range.
  function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
    hit = (a == off);
  endfunction

  assign wr_low = i_wr && hit(i_addr, CAT_OFF_COUNT_LOW);
  assign wr_high = i_wr && hit(i_addr, CAT_OFF_COUNT_HIGH);
  assign wr_mode = i_wr && hit(i_addr, CAT_OFF_MODE);
  assign wr_ctrl = i_wr && hit(i_addr, CAT_OFF_CTRL);
  assign wr_flags = i_wr && hit(i_addr, CAT_OFF_CH_FLAGS);
  assign wr_en = i_wr && hit(i_addr, CAT_OFF_CH_EN);
  assign wr_chan = i_wr && (i_addr >= CAT_OFF_CH_MODE0);
  assign rd_low = i_rd && hit(i_addr, CAT_OFF_COUNT_LOW);

  // The oscillator divider runs in the oscillator domain; only its MSB crosses.
  always_ff @(posedge i_ext_osc or negedge i_rstn) begin
    if (!i_rstn) begin
      osc_div_q <= 3'h0;
    end else begin
      osc_div_q <= osc_div_q + 3'h1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      osc_sync_q <= 3'h0;
    end else begin
      osc_sync_q <= {osc_sync_q[1:0], osc_div_q[2]};
    end
  end

  // Resetting the chain high means a pin held high gives no false edge.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pin_sync_q <= 3'h7;
    end else begin
      pin_sync_q <= {pin_sync_q[1:0], i_external_count_pin};
    end
  end

  // Prescalers run free so a timebase change never waits on stale state.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      div12_q <= 4'h0;
    end else begin
      div12_q <= (div12_q == CAT_DIV12_LAST) ? 4'h0 : div12_q + 4'h1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      div4_q <= 2'h0;
    end else begin
      div4_q <= div4_q + 2'h1;
    end
  end

  assign run = !(mode_q[CAT_MODE_IDLE_BIT] && i_cpu_idle);
  assign wdt_on = mode_q[CAT_MODE_WDT_BIT];

  always_comb begin
    case (mode_q[CAT_MODE_TB_LSB +: 3])
      CAT_TB_DIV12: tick = (div12_q == CAT_DIV12_LAST);
      CAT_TB_DIV4: tick = (div4_q == CAT_DIV4_LAST);
      CAT_TB_T0OVF: tick = i_timer0_ovf;
      CAT_TB_PIN: tick = pin_sync_q[2] && !pin_sync_q[1];
      CAT_TB_SYS: tick = 1'b1;
      CAT_TB_EXTOSC: tick = osc_sync_q[2] && !osc_sync_q[1];
      default: tick = 1'b0;
    endcase
  end

  assign wrap = run && tick && (count_q == 16'hFFFF);

  // Carry out of bit 8..11 means the low N bits are all ones on a tick.
  function automatic logic low_full(input logic [15:0] c, input logic [1:0] len);
    case (len)
      2'h0: low_full = &c[7:0];
      2'h1: low_full = &c[8:0];
      2'h2: low_full = &c[9:0];
      default: low_full = &c[10:0];
    endcase
  endfunction

  assign mid_ovf = run && tick && low_full(count_q, ctrl_q[CAT_CTRL_LEN_LSB +: 2]);

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      count_q <= 16'h0000;
    end else if (wr_low && !wdt_on) begin
      count_q[7:0] <= i_wdata;
    end else if (wr_high && !wdt_on) begin
      count_q[15:8] <= i_wdata;
    end else if (run && tick) begin
      count_q <= count_q + 16'h0001;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      snap_q <= 8'h00;
    end else if (rd_low) begin
      snap_q <= count_q[15:8];
    end
  end

  // Mode register; while the watchdog is on only the watchdog bit may be changed.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      mode_q <= CAT_MODE_RST;
    end else if (wr_mode) begin
      if (wdt_on) begin
        mode_q[CAT_MODE_WDT_BIT] <= i_wdata[CAT_MODE_WDT_BIT];
      end else begin
        mode_q <= i_wdata;
      end
    end
  end

  // Set wins over a software clear in the same cycle.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl_q <= 8'h00;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= i_wdata;
      end
      if (wrap) begin
        ctrl_q[CAT_CTRL_CF_BIT] <= 1'b1;
      end
      if (mid_ovf) begin
        ctrl_q[CAT_CTRL_INTERMEDIATE_OVERFLOW_FLAG_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cex_s1_q <= '0;
      cex_s2_q <= '0;
      cex_s3_q <= '0;
    end else begin
      cex_s1_q <= i_channel_io_line;
      cex_s2_q <= cex_s1_q;
      cex_s3_q <= cex_s2_q;
    end
  end

  genvar g;
  generate
    for (g = 0; g < CAT_NCH; g++) begin : gen_ch
      logic rise;
      logic fall;
      logic match;
      logic cap;
      logic pwm8;
      logic pwm_hi;
      logic [7:0] m;
      logic [10:0] len_mask;
      assign m = ch_mode_q[g];
      assign rise = cex_s2_q[g] && !cex_s3_q[g];
      assign fall = !cex_s2_q[g] && cex_s3_q[g];
      assign cap = (m[CAT_CH_CAPP_BIT] && rise) || (m[CAT_CH_CAPN_BIT] && fall);
      assign match = m[CAT_CH_ECOM_BIT] && (count_q == ch_cmp_q[g]);
      assign len_mask = {{3{1'b1}}, 8'hFF} >> (2'h3 - ctrl_q[CAT_CTRL_LEN_LSB +: 2]);
      assign pwm8 = m[CAT_CH_PWM_BIT] && !m[CAT_CH_PWM16_BIT];
      // PWM output is high once the counter reaches the compare value.
      always_comb begin
        if (m[CAT_CH_PWM16_BIT]) begin
          pwm_hi = (count_q >= ch_cmp_q[g]);
        end else begin
          pwm_hi = ((count_q[10:0] & len_mask) >= (ch_cmp_q[g][10:0] & len_mask));
        end
      end
      assign ch_set[g] = cap || (match && m[CAT_CH_MAT_BIT]);

      always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          ch_cap_q[g] <= 16'h0000;
        end else if (cap) begin
          ch_cap_q[g] <= count_q;
        end
      end

      always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          ch_out_q[g] <= 1'b0;
        end else begin
          if (m[CAT_CH_PWM_BIT] || pwm8) begin
            ch_out_q[g] <= m[CAT_CH_ECOM_BIT] && pwm_hi;
          end else if (m[CAT_CH_TOG_BIT] && match && run && tick) begin
            ch_out_q[g] <= !ch_out_q[g];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ch_en_q <= '0;
    end else if (wr_en) begin
      ch_en_q <= i_wdata[CAT_NCH-1:0];
    end
  end

  // A channel event in the cycle of a software clear keeps its flag set.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ch_flag_q <= '0;
    end else begin
      ch_flag_q <= (wr_flags ? i_wdata[CAT_NCH-1:0] : ch_flag_q) | ch_set;
    end
  end

  // Channel registers: mode per channel; compare values are never written and stay zero.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int i = 0; i < CAT_NCH; i++) begin
        ch_mode_q[i] <= 8'h00;
        ch_cmp_q[i] <= 16'h0000;
      end
    end else if (wr_chan) begin
      for (int i = 0; i < CAT_NCH; i++) begin
        if (i_addr[2:0] == 3'(i) && !(wdt_on && i == CAT_WDT_CH)) begin
          ch_mode_q[i] <= i_wdata;
        end
      end
    end
  end

  // Unmapped addresses read as zero so software never sees stale data.
  always_comb begin
    rd_mux = 8'h00;
    case (i_addr)
      CAT_OFF_COUNT_LOW: rd_mux = count_q[7:0];
      CAT_OFF_COUNT_HIGH: rd_mux = snap_q;
      CAT_OFF_MODE: rd_mux = mode_q;
      CAT_OFF_CTRL: rd_mux = ctrl_q;
      CAT_OFF_CH_FLAGS: rd_mux = {2'h0, ch_flag_q};
      CAT_OFF_CH_EN: rd_mux = {2'h0, ch_en_q};
      default: begin
        if (i_addr >= CAT_OFF_CH_MODE0 && i_addr[2:0] < 3'(CAT_NCH)) begin
          rd_mux = ch_mode_q[i_addr[2:0]];
        end
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= i_rd ? rd_mux : 8'h00;
    end
  end

  // The request is registered, so it lags its flags by one cycle.
  assign src_cf = ctrl_q[CAT_CTRL_CF_BIT] && mode_q[CAT_MODE_CFEN_BIT];
  assign src_intermediate_overflow_flag = ctrl_q[CAT_CTRL_INTERMEDIATE_OVERFLOW_FLAG_BIT] && ctrl_q[CAT_CTRL_COVEN_BIT];
  assign src_ch = |(ch_flag_q & ch_en_q);
  assign irq_d = i_global_irq_enable && i_array_irq_enable &&
    (src_cf || src_intermediate_overflow_flag || src_ch);

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= irq_d;
    end
  end

  assign o_channel_io_line = ch_out_q;
endmodule
`default_nettype wire

// ===== design/cat_pkg.sv
// Package with register map, field layout, reset values and timing constants for the counter array.
package cat_pkg;
  // Register offsets on the plain register port.
  localparam logic [3:0] CAT_OFF_COUNT_LOW = 4'h0;
  localparam logic [3:0] CAT_OFF_COUNT_HIGH = 4'h1;
  localparam logic [3:0] CAT_OFF_MODE = 4'h2;
  localparam logic [3:0] CAT_OFF_CTRL = 4'h3;
  localparam logic [3:0] CAT_OFF_CH_FLAGS = 4'h4;
  localparam logic [3:0] CAT_OFF_CH_EN = 4'h5;
  localparam logic [3:0] CAT_OFF_CH_MODE0 = 4'h8;
  // Mode register fields.
  localparam int CAT_MODE_IDLE_BIT = 7;
  localparam int CAT_MODE_WDT_BIT = 6;
  localparam int CAT_MODE_TB_LSB = 1;
  localparam int CAT_MODE_CFEN_BIT = 0;
  localparam logic [7:0] CAT_MODE_RST = 8'h40;
  // Control register fields.
  localparam int CAT_CTRL_CF_BIT = 7;
  localparam int CAT_CTRL_INTERMEDIATE_OVERFLOW_FLAG_BIT = 6;
  localparam int CAT_CTRL_COVEN_BIT = 5;
  localparam int CAT_CTRL_LEN_LSB = 0;
  // Channel mode register fields.
  localparam int CAT_CH_CAPP_BIT = 5;
  localparam int CAT_CH_CAPN_BIT = 4;
  localparam int CAT_CH_MAT_BIT = 3;
  localparam int CAT_CH_TOG_BIT = 2;
  localparam int CAT_CH_PWM_BIT = 1;
  localparam int CAT_CH_PWM16_BIT = 7;
  localparam int CAT_CH_ECOM_BIT = 6;
  // Geometry and timebase constants.
  localparam int CAT_NCH = 6;
  localparam int CAT_WDT_CH = 5;
  localparam logic [3:0] CAT_DIV12_LAST = 4'hb;
  localparam logic [1:0] CAT_DIV4_LAST = 2'h3;
  localparam logic [2:0] CAT_DIV8_LAST = 3'h7;
  typedef enum logic [2:0] {
    CAT_TB_DIV12, CAT_TB_DIV4, CAT_TB_T0OVF, CAT_TB_PIN, CAT_TB_SYS, CAT_TB_EXTOSC
  } cat_tb_t;
endpackage

// ===== sim/cat_counter_array_properties.sv
// Checker for the counter array register port and interrupt request.
`timescale 1ns/1ps
`default_nettype none
module cat_counter_array_props
  import cat_pkg::*;
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rstn,
  // Register port.
  input wire logic [3:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  // Interrupt gating.
  input wire logic i_global_irq_enable,
  input wire logic i_array_irq_enable,
  input wire logic o_irq
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  logic mode_wr_q;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      mode_wr_q <= 1'b0;
    end else if (i_wr && i_addr == CAT_OFF_MODE) begin
      mode_wr_q <= 1'b1;
    end
  end
  property p_glb; !i_global_irq_enable |=> !o_irq; endproperty
  a_glb: assert property (p_glb) else $error("request with global enable off");
  property p_arr; !i_array_irq_enable |=> !o_irq; endproperty
  a_arr: assert property (p_arr) else $error("request with block enable off");
  property p_quiet; !i_rd |=> o_rdata == 8'h00; endproperty
  a_quiet: assert property (p_quiet) else $error("read data without a read");
  property p_snap;
    (i_rd && i_addr == CAT_OFF_COUNT_HIGH) ##1 (i_rd && i_addr == CAT_OFF_COUNT_HIGH)
      |=> o_rdata == $past(o_rdata);
  endproperty
  a_snap: assert property (p_snap) else $error("high byte moved between reads");
  property p_cf;
    (i_rd && i_addr == CAT_OFF_CTRL) ##1 (i_rd && i_addr == CAT_OFF_CTRL && o_rdata[7])
      |=> o_rdata[7];
  endproperty
  a_cf: assert property (p_cf) else $error("overflow flag cleared by hardware");
  property p_intermediate_overflow_flag;
    (i_rd && i_addr == CAT_OFF_CTRL) ##1 (i_rd && i_addr == CAT_OFF_CTRL && o_rdata[6])
      |=> o_rdata[6];
  endproperty
  a_intermediate_overflow_flag: assert property (p_intermediate_overflow_flag) else $error("intermediate flag lost");
  property p_chf;
    (i_rd && i_addr == CAT_OFF_CH_FLAGS) ##1 (i_rd && i_addr == CAT_OFF_CH_FLAGS)
      |=> (o_rdata & $past(o_rdata)) == $past(o_rdata);
  endproperty
  a_chf: assert property (p_chf) else $error("channel flag lost");
  property p_wdt; i_rd && i_addr == CAT_OFF_MODE && !mode_wr_q |=> o_rdata[6]; endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog off after reset");
endmodule
`default_nettype wire

// ===== sim/cat_counter_array_bench.sv
// Self-checking bench for the counter array.
`timescale 1ns/1ps
`default_nettype none
module cat_counter_array_bench;
  import cat_pkg::*;
  logic i_clk = 0, i_rstn = 0, i_wr = 0, i_rd = 0, i_cpu_idle = 0, i_timer0_ovf = 0;
  logic i_global_irq_enable = 0, i_array_irq_enable = 0, i_external_count_pin = 0;
  logic i_ext_osc = 0, o_irq, rd_pend = 0;
  logic [3:0] i_addr = 0;
  logic [7:0] i_wdata = 0, o_rdata, exp_q[$];
  logic [5:0] i_channel_io_line = 0, o_channel_io_line;
  logic [7:0] tbl [8] = '{8'h02, 8'h06, 8'h03, 8'h02, 8'h18, 8'h02, 8'h00, 8'h00};
  logic [15:0] v;
  int errors = 0, checks_done = 0, seed = 29539;
  always #10 i_clk = ~i_clk;
  // A div8 tick every 240 ns is exactly 12 clocks, so its phase never drifts.
  always #15 i_ext_osc = ~i_ext_osc;
  cat_counter_array uut (.i_clk, .i_rstn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_cpu_idle, .i_timer0_ovf, .i_global_irq_enable, .i_array_irq_enable,
    .i_external_count_pin, .i_ext_osc, .i_channel_io_line, .o_channel_io_line, .o_irq);
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask
  always @(posedge i_clk) rd_pend <= i_rd;
  always @(negedge i_clk) begin
    if (rd_pend) check(o_rdata, exp_q.pop_front());
  end
  task wr(input logic [3:0] a, input logic [7:0] d);
    i_wr <= 1;
    i_rd <= 0;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e);
    i_rd <= 1;
    i_wr <= 0;
    i_addr <= a;
    exp_q.push_back(e);
    @(posedge i_clk);
  endtask
  task idle(input int n);
    i_wr <= 0;
    i_rd <= 0;
    repeat (n) @(posedge i_clk);
  endtask
  task automatic irq(input logic e);
    idle(2);
    fork
      #1 check({7'h00, o_irq}, {7'h00, e});
    join_none
  endtask
  // Code 6 holds the count, so values can be loaded and read back calmly.
  task setc(input logic [15:0] s);
    wr(CAT_OFF_MODE, 8'h0C);
    wr(CAT_OFF_COUNT_LOW, s[7:0]);
    wr(CAT_OFF_COUNT_HIGH, s[15:8]);
  endtask
  // Any 24-clock window holds a whole number of ticks of every periodic source.
  task tb(input logic [7:0] m, input logic [7:0] e);
    setc(16'h0000);
    wr(CAT_OFF_MODE, m);
    idle(0);
    for (int n = 0; n < 23; n++) begin
      i_timer0_ovf <= (n % 8 == 2);
      i_external_count_pin <= n[2];
      @(posedge i_clk);
    end
    wr(CAT_OFF_MODE, 8'h0C);
    i_external_count_pin <= 0;
    rd(CAT_OFF_COUNT_LOW, e);
  endtask
  task intermediate_overflow_flag(input logic [1:0] l, input logic [15:0] s, input logic [7:0] e);
    setc(s);
    wr(CAT_OFF_CTRL, {6'h00, l});
    wr(CAT_OFF_MODE, 8'h08);
    idle(5);
    wr(CAT_OFF_MODE, 8'h0C);
    rd(CAT_OFF_CTRL, e);
  endtask
  task summarize;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #100000;
    errors++;
    summarize();
  end
  initial begin
    repeat (5) @(posedge i_clk);
    i_rstn <= 1;
    rd(CAT_OFF_MODE, 8'h40);
    wr(CAT_OFF_MODE, 8'h4C);
    rd(CAT_OFF_MODE, 8'h40);
    wr(CAT_OFF_MODE, 8'h00);
    rd(CAT_OFF_MODE, 8'h00);
    v = 16'($random(seed));
    setc(v);
    rd(CAT_OFF_COUNT_LOW, v[7:0]);
    wr(CAT_OFF_COUNT_HIGH, ~v[15:8]);
    rd(CAT_OFF_COUNT_HIGH, v[15:8]);
    rd(CAT_OFF_COUNT_HIGH, v[15:8]);
    rd(CAT_OFF_COUNT_LOW, v[7:0]);
    rd(CAT_OFF_COUNT_HIGH, ~v[15:8]);
    rd(4'h7, 8'h00);
    $display("snapshot test done");
    for (int c = 0; c < 8; c++) tb({4'h0, c[2:0], 1'b0}, tbl[c]);
    i_cpu_idle <= 1;
    tb(8'h88, 8'h00);
    tb(8'h08, 8'h18);
    i_cpu_idle <= 0;
    $display("timebase test done");
    for (int n = 0; n < 4; n++) begin
      intermediate_overflow_flag(n[1:0], 16'((17'h1 << (n + 8)) - 2), 8'h40 | 8'(n));
      if (n > 0) intermediate_overflow_flag(n[1:0], 16'((17'h1 << (n + 7)) - 2), 8'(n));
    end
    $display("intermediate test done");
    i_global_irq_enable <= 1;
    i_array_irq_enable <= 1;
    setc(16'hFFFE);
    wr(CAT_OFF_CTRL, 8'h00);
    wr(CAT_OFF_MODE, 8'h08);
    idle(5);
    wr(CAT_OFF_MODE, 8'h0C);
    rd(CAT_OFF_CTRL, 8'hC0);
    rd(CAT_OFF_CTRL, 8'hC0);
    irq(0);
    wr(CAT_OFF_MODE, 8'h0D);
    irq(1);
    i_global_irq_enable <= 0;
    irq(0);
    i_global_irq_enable <= 1;
    irq(1);
    i_array_irq_enable <= 0;
    irq(0);
    i_array_irq_enable <= 1;
    wr(CAT_OFF_CTRL, 8'h00);
    irq(0);
    wr(CAT_OFF_CH_FLAGS, 8'h20);
    irq(0);
    rd(CAT_OFF_CH_FLAGS, 8'h20);
    rd(CAT_OFF_CH_FLAGS, 8'h20);
    wr(CAT_OFF_CH_EN, 8'h20);
    irq(1);
    wr(CAT_OFF_CH_MODE0, 8'h20);
    i_channel_io_line <= 6'h01;
    idle(4);
    rd(CAT_OFF_CH_FLAGS, 8'h21);
    wr(CAT_OFF_CH_MODE0 | 4'h1, 8'hC2);
    idle(2);
    fork
      #1 check({2'h0, o_channel_io_line}, 8'h02);
    join_none
    idle(3);
    $display("interrupt test done");
    summarize();
  end
endmodule
bind cat_counter_array cat_counter_array_props u_props (.i_clk, .i_rstn, .i_addr, .i_wr,
  .i_rd, .o_rdata, .i_global_irq_enable, .i_array_irq_enable, .o_irq);
`default_nettype wire
